// file: verilog/elm_pkg.sv
package elm_pkg;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_HZ_DEF = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int CLR_NS = 15000;
    localparam int CLR_CYC = (CLR_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_NS = 1900;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ALARM_N = 16;
    localparam int NLINE = 8;
    localparam int CNT_W = 19;

    // ****************************************************
    // register map (byte offsets) and field positions
    // ****************************************************
    localparam logic [2:0] OFS_CSR = 3'h0;
    localparam logic [2:0] OFS_RECEIVE_SILO_WORD = 3'h2;
    localparam logic [2:0] OFS_TCR = 3'h4;
    localparam logic [2:0] OFS_TDR = 3'h6;
    localparam int B_LOOPBACK_TEST = 3;
    localparam int B_CLR = 4;
    localparam int B_MSE = 5;
    localparam int B_RIE = 6;
    localparam int B_RECEIVE_DONE_FLAG = 7;
    localparam int B_TLINE = 8;
    localparam int B_SAE = 12;
    localparam int B_SA = 13;
    localparam int B_TIE = 14;
    localparam int B_TRANSMIT_READY_FLAG = 15;
    localparam int L_CFG = 3;
    localparam int L_TOP = 12;
    localparam int R_DV = 15;

    // field order matches line_parameters bits 12..3
    typedef struct packed {
        logic rx_on;
        logic [3:0] speed;
        logic par_odd;
        logic par_en;
        logic stop2;
        logic [1:0] len;
    } elm_cfg_t;

    typedef struct packed {
        elm_cfg_t cfg;
        logic [CNT_W-1:0] tcnt;
        logic [4:0] thalf;
        logic tph;
        logic [11:0] tsh;
        logic tfull;
        logic [7:0] transmit_char_byte;
        logic [CNT_W-1:0] rcnt;
        logic [3:0] rpos;
        logic ract;
        logic [11:0] rsh;
        logic hold;
        logic [14:0] hword;
        logic txd;
    } elm_line_t;

    // baud rate times ten for each speed code
    function automatic int elm_baud10(input logic [3:0] c);
        case (c)
            4'h0: return 500;
            4'h1: return 750;
            4'h2: return 1100;
            4'h3: return 1345;
            4'h4: return 1500;
            4'h5: return 3000;
            4'h6: return 6000;
            4'h7: return 12000;
            4'h8: return 18000;
            4'h9: return 20000;
            4'hA: return 24000;
            4'hB: return 36000;
            4'hC: return 48000;
            4'hD: return 72000;
            default: return 96000;
        endcase
    endfunction : elm_baud10

endpackage : elm_pkg

// file: verilog/elm_serial_mux.sv
`timescale 1ns/1ps
module elm_serial_mux
    import elm_pkg::*;
#(
    parameter int CLK_HZ = CLK_HZ_DEF,
    parameter int SILO_DEPTH = 64,
    parameter bit MODEM = 1'b1
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [1:0] reg_be,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [7:0] rx_pin,
    input wire logic [7:0] ring_lead,
    input wire logic [7:0] carrier_lead,
    output logic [7:0] tx_pin,
    output logic [7:0] terminal_ready,
    output logic rx_irq,
    output logic tx_irq
);

    localparam int PW = $clog2(SILO_DEPTH);
    localparam int CW = $clog2(CLR_CYC + 1);
    localparam int CLR_D = CLR_CYC;

    if (SILO_DEPTH < 2 || (SILO_DEPTH & (SILO_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("silo depth must be a power of two");
    end
    if (CLK_HZ / 100 >= (1 << CNT_W) || CLK_HZ < 200_000)
    begin : g_bad_clk
        $error("clock rate outside divider range");
    end

    typedef struct packed {
        logic [23:0] sy1;
        logic [23:0] sy2;
        logic loopback_test;
        logic mse;
        logic rie;
        logic alarm_enable;
        logic sa;
        logic transmit_irq_enable;
        logic transmit_ready_flag;
        logic [2:0] tline;
        logic [2:0] scan;
        logic [CW-1:0] clr_cnt;
        logic [5:0] gap;
        logic [4:0] acnt;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic [7:0] lnen;
        logic [7:0] dtr;
        logic [7:0] line_break;
        logic [15:0] rdata;
        elm_line_t [NLINE-1:0] ln;
    } elm_state_t;

    elm_state_t s;
    elm_state_t next_s;
    logic [14:0] silo [SILO_DEPTH];
    logic we;
    logic [14:0] wd;

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [CNT_W-1:0] half_cyc(input elm_cfg_t c);
        int h;
        h = CLK_HZ / 2 * 10 / elm_baud10(c.speed);
        return CNT_W'(h);
    endfunction : half_cyc

    function automatic logic [3:0] nbits(input elm_cfg_t c);
        return 4'(c.len) + 4'h5;
    endfunction : nbits

    function automatic logic [7:0] mask_char(input elm_cfg_t c,
                                             input logic [7:0] d);
        logic [7:0] m;
        m = d;
        for (int j = 0; j < 8; j++)
        begin
            if (4'(j) >= nbits(c))
            begin
                m[j] = 1'b0;
            end
        end
        return m;
    endfunction : mask_char

    function automatic logic [11:0] tx_frame(input elm_cfg_t c,
                                             input logic [7:0] d);
        logic [11:0] f;
        logic [7:0] m;
        m = mask_char(c, d);
        f = 12'hFFF;
        f[0] = 1'b0;
        for (int j = 0; j < 8; j++)
        begin
            if (4'(j) < nbits(c))
            begin
                f[j+1] = m[j];
            end
        end
        if (c.par_en)
        begin
            f[nbits(c) + 4'h1] = ^m ^ c.par_odd;
        end
        return f;
    endfunction : tx_frame

    function automatic logic [4:0] tx_halves(input elm_cfg_t c);
        logic [4:0] sh;
        sh = !c.stop2 ? 5'h2 : (c.len == 2'h0 ? 5'h3 : 5'h4);
        return 5'((5'h1 + 5'(nbits(c)) + 5'(c.par_en)) << 1) + sh;
    endfunction : tx_halves

    function automatic logic [3:0] last_pos(input elm_cfg_t c);
        return nbits(c) + 4'(c.par_en) + 4'h1;
    endfunction : last_pos

    function automatic logic [14:0] rx_word(input elm_cfg_t c,
                                            input logic [11:0] r,
                                            input logic [2:0] line,
                                            input logic ovr);
        logic [7:0] m;
        logic perr;
        m = mask_char(c, r[8:1]);
        perr = c.par_en && ((^m ^ r[nbits(c) + 4'h1]) != c.par_odd);
        return {ovr, !r[last_pos(c)], perr, 1'b0, line, m};
    endfunction : rx_word

    // ****************************************************
    // next state
    // ****************************************************
    logic wr_csr;
    logic wr_lpr;
    logic wr_tcr;
    logic wr_tdr;
    logic rd_receive_silo_word;
    logic receive_done_flag;
    assign wr_csr = reg_wr && reg_addr[2:1] == OFS_CSR[2:1];
    assign wr_lpr = reg_wr && reg_addr[2:1] == OFS_RECEIVE_SILO_WORD[2:1];
    assign wr_tcr = reg_wr && reg_addr[2:1] == OFS_TCR[2:1];
    assign wr_tdr = reg_wr && reg_addr[2:1] == OFS_TDR[2:1];
    assign rd_receive_silo_word = reg_rd && reg_addr[2:1] == OFS_RECEIVE_SILO_WORD[2:1];
    assign receive_done_flag = s.cnt != '0;

    always_comb
    begin
        logic rxb;
        logic txraw;
        logic [11:0] rs;
        logic [CNT_W-1:0] hc;
        logic [3:0] sel;
        elm_cfg_t c;
        rxb = 1'b1;
        txraw = 1'b1;
        rs = '0;
        hc = '0;
        sel = 4'h8;
        c = '0;
        next_s = s;
        we = 1'b0;
        wd = '0;
        next_s.sy1 = {carrier_lead, ring_lead, rx_pin};
        next_s.sy2 = s.sy1;
        if (wr_csr && reg_be[0])
        begin
            next_s.loopback_test = reg_wdata[B_LOOPBACK_TEST];
            next_s.mse = reg_wdata[B_MSE];
            next_s.rie = reg_wdata[B_RIE];
            if (reg_wdata[B_CLR])
            begin
                next_s.clr_cnt = CW'(CLR_CYC);
            end
        end
        if (wr_csr && reg_be[1])
        begin
            next_s.alarm_enable = reg_wdata[B_SAE];
            next_s.transmit_irq_enable = reg_wdata[B_TIE];
        end
        if (wr_tcr && reg_be[0])
        begin
            next_s.lnen = reg_wdata[7:0];
        end
        if (wr_tcr && reg_be[1] && MODEM)
        begin
            next_s.dtr = reg_wdata[15:8];
        end
        if (wr_tdr && reg_be[1])
        begin
            next_s.line_break = reg_wdata[15:8];
        end
        if (wr_tdr && reg_be[0] && s.transmit_ready_flag)
        begin
            next_s.ln[s.tline].transmit_char_byte = reg_wdata[7:0];
            next_s.ln[s.tline].tfull = 1'b1;
            next_s.transmit_ready_flag = 1'b0;
            next_s.gap = 6'(GAP_CYC);
        end
        if (wr_lpr && reg_be == 2'h3)
        begin
            next_s.ln[reg_wdata[2:0]].cfg = reg_wdata[L_TOP:L_CFG];
        end
        if (s.transmit_ready_flag && !next_s.lnen[s.tline])
        begin
            next_s.transmit_ready_flag = 1'b0;
        end
        // transmit scanner
        if (s.gap != '0)
        begin
            next_s.gap = s.gap - 6'h1;
        end
        else if (s.mse && !s.transmit_ready_flag)
        begin
            if (next_s.lnen[s.scan] && !s.ln[s.scan].tfull)
            begin
                next_s.transmit_ready_flag = 1'b1;
                next_s.tline = s.scan;
            end
            next_s.scan = s.scan + 3'h1;
        end
        // register read and silo advance
        if (reg_rd)
        begin
            case (reg_addr[2:1])
                OFS_CSR[2:1]: next_s.rdata = {s.transmit_ready_flag, s.transmit_irq_enable, s.sa, s.alarm_enable,
                    1'b0, s.tline, receive_done_flag, s.rie, s.mse, s.clr_cnt != '0,
                    s.loopback_test, 3'h0};
                OFS_RECEIVE_SILO_WORD[2:1]: next_s.rdata = {receive_done_flag, silo[s.rp]};
                OFS_TCR[2:1]: next_s.rdata = {MODEM ? s.dtr : 8'h00, s.lnen};
                default: next_s.rdata = MODEM ? s.sy2[23:8] : 16'h0000;
            endcase
        end
        if (rd_receive_silo_word)
        begin
            next_s.sa = 1'b0;
            next_s.acnt = '0;
            if (receive_done_flag)
            begin
                next_s.rp = s.rp + PW'(1);
            end
        end
        // one silo write a cycle, lowest line first
        for (int i = NLINE - 1; i >= 0; i--)
        begin
            if (s.ln[i].hold)
            begin
                sel = 4'(i);
            end
        end
        if (sel != 4'h8 && s.mse)
        begin
            next_s.ln[sel[2:0]].hold = 1'b0;
            if (s.cnt != (PW+1)'(SILO_DEPTH))
            begin
                we = 1'b1;
                wd = s.ln[sel[2:0]].hword;
                next_s.wp = s.wp + PW'(1);
                if (next_s.acnt == 5'(ALARM_N - 1))
                begin
                    next_s.sa = 1'b1;
                    next_s.acnt = '0;
                end
                else
                begin
                    next_s.acnt = next_s.acnt + 5'h1;
                end
            end
        end
        next_s.cnt = s.cnt + (PW+1)'(we) - (PW+1)'(rd_receive_silo_word && receive_done_flag);
        // per-line serializers
        for (int i = 0; i < NLINE; i++)
        begin
            c = s.ln[i].cfg;
            hc = half_cyc(c);
            txraw = s.ln[i].thalf != '0 ? s.ln[i].tsh[0] : 1'b1;
            if (s.ln[i].thalf != '0)
            begin
                if (s.ln[i].tcnt == '0)
                begin
                    next_s.ln[i].tcnt = hc - CNT_W'(1);
                    next_s.ln[i].thalf = s.ln[i].thalf - 5'h1;
                    next_s.ln[i].tph = !s.ln[i].tph;
                    if (s.ln[i].tph)
                    begin
                        next_s.ln[i].tsh = {1'b1, s.ln[i].tsh[11:1]};
                    end
                end
                else
                begin
                    next_s.ln[i].tcnt = s.ln[i].tcnt - CNT_W'(1);
                end
            end
            else if (s.ln[i].tfull && s.mse)
            begin
                next_s.ln[i].tsh = tx_frame(c, s.ln[i].transmit_char_byte);
                next_s.ln[i].thalf = tx_halves(c);
                next_s.ln[i].tcnt = hc - CNT_W'(1);
                next_s.ln[i].tph = 1'b0;
                next_s.ln[i].tfull = 1'b0;
            end
            next_s.ln[i].txd = s.loopback_test ? 1'b1 : !s.line_break[i] && txraw;
            rxb = s.loopback_test ? txraw : s.sy2[i];
            rs = s.ln[i].rsh;
            rs[s.ln[i].rpos] = rxb;
            if (!(s.mse && c.rx_on))
            begin
                next_s.ln[i].ract = 1'b0;
            end
            else if (!s.ln[i].ract)
            begin
                if (!rxb)
                begin
                    next_s.ln[i].ract = 1'b1;
                    next_s.ln[i].rcnt = hc - CNT_W'(1);
                    next_s.ln[i].rpos = '0;
                end
            end
            else if (s.ln[i].rcnt != '0)
            begin
                next_s.ln[i].rcnt = s.ln[i].rcnt - CNT_W'(1);
            end
            else
            begin
                next_s.ln[i].rsh = rs;
                next_s.ln[i].rcnt = CNT_W'({hc, 1'b0} - 1);
                next_s.ln[i].rpos = s.ln[i].rpos + 4'h1;
                if (s.ln[i].rpos == '0 && rxb)
                begin
                    next_s.ln[i].ract = 1'b0;
                end
                else if (s.ln[i].rpos == last_pos(c))
                begin
                    next_s.ln[i].ract = 1'b0;
                    next_s.ln[i].hword = rx_word(c, rs, 3'(i),
                        next_s.ln[i].hold);
                    next_s.ln[i].hold = 1'b1;
                end
            end
            if (!s.mse)
            begin
                next_s.ln[i].hold = 1'b0;
            end
        end
        if (!s.mse)
        begin
            next_s.cnt = '0;
            next_s.rp = next_s.wp;
            next_s.transmit_ready_flag = 1'b0;
        end
        // programmed clear pulse holds everything but modem leads, scan, wp and rdata
        if (s.clr_cnt != '0)
        begin
            next_s.clr_cnt = s.clr_cnt - CW'(1);
            next_s.loopback_test = 1'b0;
            next_s.mse = 1'b0;
            next_s.rie = 1'b0;
            next_s.alarm_enable = 1'b0;
            next_s.sa = 1'b0;
            next_s.transmit_irq_enable = 1'b0;
            next_s.transmit_ready_flag = 1'b0;
            next_s.tline = '0;
            next_s.gap = '0;
            next_s.acnt = '0;
            next_s.cnt = '0;
            next_s.rp = next_s.wp;
            next_s.lnen = '0;
            next_s.line_break = '0;
            for (int i = 0; i < NLINE; i++)
            begin
                next_s.ln[i] = '0;
                next_s.ln[i].txd = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            for (int i = 0; i < NLINE; i++)
            begin
                s.ln[i].txd <= 1'b1;
            end
        end
        else
        begin
            s <= next_s;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (we)
        begin
            silo[s.wp] <= wd;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    always_comb
    begin
        for (int i = 0; i < NLINE; i++)
        begin
            tx_pin[i] = s.ln[i].txd;
        end
    end
    assign reg_rdata = s.rdata;
    assign terminal_ready = s.dtr;
    assign rx_irq = s.rie && (s.alarm_enable ? s.sa : receive_done_flag);
    assign tx_irq = s.transmit_irq_enable && s.transmit_ready_flag;

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_clear_pulse_len: assert property ($rose(s.clr_cnt != '0) |->
        ##CLR_D $fell(s.clr_cnt != '0)) else $error("clear pulse length");
    a_clear_zeroes_csr: assert property ((s.clr_cnt != '0) |=>
        !s.mse && !s.loopback_test && !s.transmit_ready_flag && s.tline == '0)
        else $error("clear left control bits set");
    a_alarm_masks_done: assert property ((s.alarm_enable && !s.sa) |->
        !rx_irq) else $error("receive-done interrupted under alarm");
    a_tx_irq_cause: assert property (tx_irq |-> s.transmit_ready_flag && s.transmit_irq_enable)
        else $error("transmit interrupt without ready");
    a_ready_line_ok: assert property (s.transmit_ready_flag |->
        s.lnen[s.tline] && !s.ln[s.tline].tfull)
        else $error("ready names a busy or disabled line");
    a_scan_gap_hold: assert property (($fell(s.transmit_ready_flag) && s.gap != '0) |->
        !s.transmit_ready_flag [*8]) else $error("ready returned too soon");
    a_scan_off_empty: assert property (!s.mse |=> !receive_done_flag)
        else $error("silo not empty with scan off");
    a_break_forces: assert property ((s.line_break[2] && !s.loopback_test &&
        s.clr_cnt == '0) |=> !tx_pin[2])
        else $error("break did not force zero");
    a_read_clears_sa: assert property ((rd_receive_silo_word && !we) |=> !s.sa)
        else $error("alarm survived read");

    c_valid_read: cover property (rd_receive_silo_word && receive_done_flag);
    c_alarm: cover property ($rose(s.sa));
    c_ready: cover property ($rose(s.transmit_ready_flag) && s.tline != '0);
    c_clear: cover property ($fell(s.clr_cnt != '0));

endmodule : elm_serial_mux

// file: test/elm_term_model.sv
`timescale 1ns/1ps
module elm_term_model
#(
    parameter int HALF = 20
)
(
    input wire logic ref_clk,
    input wire logic [7:0] tx_pin,
    output logic [7:0] rx_pin,
    output logic [7:0] ring_lead,
    output logic [7:0] carrier_lead
);
    // ****
    // terminal side of all eight lines
    // ****
    initial
    begin
        rx_pin = 8'hFF;
        ring_lead = 8'hC3;
        carrier_lead = 8'h3C;
    end

    // start bit, n bits lsb first, then back to mark
    task automatic send(input int ln, input logic [11:0] b, input int n);
        rx_pin[ln] <= 1'b0;
        repeat (2 * HALF) @(posedge ref_clk);
        for (int i = 0; i < n; i++)
        begin
            rx_pin[ln] <= b[i];
            repeat (2 * HALF) @(posedge ref_clk);
        end
        rx_pin[ln] <= 1'b1;
        repeat (4 * HALF) @(posedge ref_clk);
    endtask : send

    // samples n bits mid-bit after the start edge
    task automatic get(input int ln, input int n, output logic [11:0] b);
        int t;
        b = '1;
        t = 0;
        while (tx_pin[ln] !== 1'b0 && t < 2000)
        begin
            @(posedge ref_clk);
            t++;
        end
        repeat (HALF) @(posedge ref_clk);
        for (int i = 0; i < n; i++)
        begin
            repeat (2 * HALF) @(posedge ref_clk);
            b[i] = tx_pin[ln];
        end
    endtask : get
endmodule : elm_term_model

// file: test/test_eight_line_async_serial_mux.sv
`timescale 1ns/1ps
module test_eight_line_async_serial_mux
    import elm_pkg::*;
;
    localparam int HZ = 400_000;
    localparam int HALF = HZ * 5 / 96000;
    typedef struct packed {
        logic [2:0] a;
        logic w;
        logic [1:0] be;
        logic [15:0] d;
        logic [15:0] e;
    } elm_row_t;
    typedef struct packed {
        logic [15:0] line_parameters;
        logic [11:0] f;
        logic [3:0] n;
        logic [15:0] e;
    } elm_rx_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = '0;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [1:0] reg_be = '0;
    logic [15:0] reg_wdata = '0;
    logic [15:0] reg_rdata;
    logic [7:0] rx_pin, ring_lead, carrier_lead, tx_pin, terminal_ready;
    logic rx_irq, tx_irq;
    int mismatches = 0;
    int checked = 0;
    logic [15:0] q;
    logic [11:0] b;
    int n;
    elm_row_t rows [6] = '{
        '{3'h0, 1'b1, 2'h3, 16'hFFEF, 16'h5068},
        '{3'h0, 1'b1, 2'h3, 16'h0000, 16'h0000},
        '{3'h4, 1'b1, 2'h3, 16'hA55A, 16'hA55A},
        '{3'h4, 1'b1, 2'h1, 16'hFFFF, 16'hA5FF},
        '{3'h6, 1'b0, 2'h3, 16'h0000, 16'h3CC3},
        '{3'h4, 1'b1, 2'h3, 16'hFF0F, 16'hFF0F}};
    elm_rx_t rxs [6] = '{
        '{16'h1E1D, 12'h13C, 4'h9, 16'h853C},
        '{16'h1E1D, 12'h081, 4'h9, 16'hA581},
        '{16'h1E5D, 12'h303, 4'hA, 16'h9503},
        '{16'h1EDD, 12'h303, 4'hA, 16'h8503},
        '{16'h1E15, 12'h0FF, 4'h8, 16'h857F},
        '{16'h1E05, 12'h035, 4'h6, 16'h8515}};

    always #25 ref_clk = ~ref_clk;

    elm_serial_mux #(.CLK_HZ(HZ)) u_elm_serial_mux (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
        .ring_lead(ring_lead), .carrier_lead(carrier_lead),
        .tx_pin(tx_pin), .terminal_ready(terminal_ready),
        .rx_irq(rx_irq), .tx_irq(tx_irq));
    elm_term_model #(.HALF(HALF)) u_elm_term_model (
        .ref_clk(ref_clk), .tx_pin(tx_pin), .rx_pin(rx_pin),
        .ring_lead(ring_lead), .carrier_lead(carrier_lead));

    // ****
    // bus tasks and checks
    // ****
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic cmp(input string nm, input logic [15:0] got,
                       input logic [15:0] ex);
        checked++;
        if (got !== ex)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp

    task automatic wr(input logic [2:0] a, input logic [15:0] d,
                      input logic [1:0] be);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        #1 v = reg_rdata;
    endtask : rd

    // reads control_status until bit k equals v; returns cycles spent
    task automatic poll(input int k, input logic v, output int c);
        logic [15:0] s;
        c = 0;
        do
        begin
            rd(3'h0, s);
            c += 3;
        end while (s[k] !== v && c < 3000);
        if (s[k] !== v)
        begin
            mismatches++;
            $display("CHECK FAILED poll bit %0d expected %b", k, v);
            end_of_test;
        end
    endtask : poll

    initial
    begin
        repeat (11) @(posedge ref_clk);
        #1 cmp("reset pins", {tx_pin, terminal_ready}, 16'hFF00);
        cmp("reset irqs", {14'h0, rx_irq, tx_irq}, 16'h0);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d, rows[i].be);
            rd(rows[i].a, q);
            cmp("register", q, rows[i].e);
        end
        cmp("terminal ready", {8'h0, terminal_ready}, 16'h00FF);
        wr(3'h6, 16'h0400, 2'h2);
        repeat (2) @(posedge ref_clk);
        #1 cmp("break pin", {8'h0, tx_pin}, 16'h00FB);
        wr(3'h0, 16'h0010, 2'h1);
        poll(4, 1'b0, n);
        cmp("clear length",
            16'(n >= CLR_CYC - 3 && n <= CLR_CYC + 6), 16'h1);
        rd(3'h0, q);
        cmp("csr after clear", q, 16'h0);
        rd(3'h4, q);
        cmp("tcr after clear", q, 16'hFF00);
        cmp("pins after clear", {tx_pin, terminal_ready}, 16'hFFFF);
        wr(3'h2, 16'h1E1D, 2'h3);
        wr(3'h4, 16'hFF20, 2'h3);
        wr(3'h0, 16'h4020, 2'h3);
        poll(15, 1'b1, n);
        rd(3'h0, q);
        cmp("ready line", q, 16'hC520);
        cmp("tx irq", {15'h0, tx_irq}, 16'h1);
        wr(3'h6, 16'h00A5, 2'h1);
        #1 cmp("tx irq after load", {15'h0, tx_irq}, 16'h0);
        u_elm_term_model.get(5, 9, b);
        cmp("sent frame", {7'h0, b[8:0]}, 16'h01A5);
        wr(3'h0, 16'h0060, 2'h3);
        foreach (rxs[i])
        begin
            wr(3'h2, rxs[i].line_parameters, 2'h3);
            u_elm_term_model.send(5, rxs[i].f, int'(rxs[i].n));
            cmp("rx irq", {15'h0, rx_irq}, 16'h1);
            rd(3'h2, q);
            cmp("received word", q, rxs[i].e);
            cmp("rx irq after read", {15'h0, rx_irq}, 16'h0);
        end
        rd(3'h2, q);
        cmp("empty silo", {15'h0, q[15]}, 16'h0);
        wr(3'h0, 16'h1060, 2'h3);
        wr(3'h2, 16'h1E1D, 2'h3);
        for (int i = 0; i < ALARM_N; i++)
        begin
            cmp("alarm irq early", {15'h0, rx_irq}, 16'h0);
            u_elm_term_model.send(5, 12'h100 | 12'(i), 9);
        end
        rd(3'h0, q);
        cmp("alarm flag", q & 16'h20A0, 16'h20A0);
        cmp("alarm irq", {15'h0, rx_irq}, 16'h1);
        for (int i = 0; i < ALARM_N; i++)
        begin
            rd(3'h2, q);
            cmp("silo order", q, 16'h8500 | 16'(i));
        end
        cmp("alarm cleared", {15'h0, rx_irq}, 16'h0);
        wr(3'h0, 16'h0028, 2'h3);
        poll(15, 1'b1, n);
        wr(3'h6, 16'h005A, 2'h1);
        repeat (200) @(posedge ref_clk);
        cmp("loop pin", {8'h0, tx_pin}, 16'h00FF);
        repeat (400) @(posedge ref_clk);
        rd(3'h2, q);
        cmp("loop word", q, 16'h855A);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        #1 cmp("reinit ready", {8'h0, terminal_ready}, 16'h0);
        end_of_test;
    end
endmodule : test_eight_line_async_serial_mux
